// ===== rtl/spi_port.v
// serial peripheral port: apb registers, master clocking, slave sampling and status flags
//
// The APB interface to the registers is this design's own decision.
`include "spi_port_regs.vh"

module spi_port (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // serial clock pin
    input wire sck_in,
    output reg sck_out,
    output wire sck_oe,
    // master out slave in pin
    input wire mosi_in,
    output wire mosi_out,
    output wire mosi_oe,
    // master in slave out pin
    input wire miso_in,
    output wire miso_out,
    output wire miso_oe,
    // slave select pin
    input wire ss_n_in,
    // interrupt request
    output wire irq
);
// ****************************************
// registers and state
// ****************************************
localparam ST_IDLE = 1'b0;
localparam ST_BUSY = 1'b1;

reg [7:0] ctrl_q;
reg [7:0] csr_sw_q;
reg done_q;
reg write_collision_flag_q;
reg ovr_q;
reg mode_fault_flag_q;
reg [7:0] rx_buf_q;
reg state_q;
reg [4:0] edge_cnt_q;
reg csr_seen_q;
reg ctrl_seen_q;
reg write_collision_flag_seen_q;
reg sck_prev_q;
reg last_cap_q;

wire [9:0] word_addr = paddr[11:2];
wire acc = psel && penable;
wire wr = acc && pwrite;
wire rd = acc && !pwrite;

// one word per register; anything else reads zero and is refused
function hit;
    input [9:0] a;
    input [9:0] r;
    begin
        hit = (a == r) && (paddr[1:0] == 2'b00);
    end
endfunction

wire sel_data = hit(word_addr, `DATA_ADDR >> 2);
wire sel_ctrl = hit(word_addr, `CTRL_ADDR >> 2);
wire sel_csr = hit(word_addr, `CSR_ADDR >> 2);

assign pready = 1'b1;
assign pslverr = acc && !(sel_data || sel_ctrl || sel_csr);

wire en = ctrl_q[`CTRL_EN];
wire master_select = ctrl_q[`CTRL_MASTER_SELECT];
wire clock_idle_polarity = ctrl_q[`CTRL_CLOCK_IDLE_POLARITY];
wire clock_capture_phase = ctrl_q[`CTRL_CLOCK_CAPTURE_PHASE];
wire select_software_manage = csr_sw_q[`CSR_SSM];
// select level seen by the port
wire ss_level = select_software_manage ? csr_sw_q[`CSR_SSI] : ss_n_in;
wire fault = en && master_select && !ss_level;
wire busy = (state_q == ST_BUSY);

// ****************************************
// software access sequences
// ****************************************
wire data_wr = wr && sel_data;
wire data_acc = acc && sel_data;
wire ctrl_wr = wr && sel_ctrl;
wire csr_rd = rd && sel_csr;
wire csr_acc = acc && sel_csr;
// writes blocked while done until status is read
wire data_wr_ok = data_wr && !(done_q && !csr_seen_q) && !busy;
wire start_master = data_wr_ok && en && master_select;

// ****************************************
// master clock divider and slave edge detection
// ****************************************
wire half_tick;

spi_clk_div u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(busy && master_select),
    .div_sel({ctrl_q[`CTRL_DIVH], ctrl_q[1:0]}),
    .half_tick(half_tick)
);

// slave: clock edges in the serial clock's own sense; divider bits ignored here
wire slv_active = en && !master_select && !ss_level;
wire sck_edge = slv_active && (sck_in != sck_prev_q);
wire edge_ev = master_select ? (busy && half_tick) : sck_edge;
// odd edges are first-half edges; with phase 0 they capture, with phase 1 they launch
wire first_half = !edge_cnt_q[0];
wire cap_ev = edge_ev && (first_half ^ clock_capture_phase);
wire launch_ev = edge_ev && !(first_half ^ clock_capture_phase) && !(clock_capture_phase && edge_cnt_q == 5'h00);
wire last_edge = edge_ev && (edge_cnt_q == 5'h0F);
wire sdi = master_select ? miso_in : mosi_in;
// phase 0 shifts on trailing edges, its first bit driven from the data write; phase 1 shifts on leading edges
wire shift_ev = (clock_capture_phase ? launch_ev : (edge_ev && !first_half));

wire [7:0] shreg;
wire sdo;

spi_shifter u_shift (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(data_wr_ok),
    .load_data(pwdata[7:0]),
    .sample(cap_ev),
    .shift(shift_ev && !last_edge || last_edge),
    .din(sdi),
    .dout(sdo),
    .data_q(shreg)
);

// byte assembled with the last captured bit: sampled on the last edge with phase 1, held from the edge before with phase 0
wire [7:0] rx_byte = clock_capture_phase ? {shreg[6:0], sdi} : {shreg[6:0], last_cap_q};
// byte end and the status-then-data sequence that clears the done flag
wire byte_end = last_edge && busy;
wire done_clr = data_acc && csr_seen_q;

// ****************************************
// last captured bit
// ****************************************
// with phase 0 the final bit is captured one edge before the byte ends
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        last_cap_q <= 1'b0;
    end else if (cap_ev) begin
        last_cap_q <= sdi;
    end
end

// ****************************************
// transfer state
// ****************************************
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_q <= ST_IDLE;
        edge_cnt_q <= 5'h00;
        sck_prev_q <= 1'b0;
        sck_out <= 1'b0;
    end else begin
        sck_prev_q <= slv_active ? sck_in : clock_idle_polarity;
        if (!en || fault || (!master_select && ss_level)) begin
            state_q <= ST_IDLE;
            edge_cnt_q <= 5'h00;
            sck_out <= clock_idle_polarity;
        end else if (start_master || (!master_select && sck_edge && !busy)) begin
            state_q <= ST_BUSY;
            edge_cnt_q <= master_select ? 5'h00 : 5'h01;
            sck_out <= clock_idle_polarity;
        end else if (busy && edge_ev) begin
            if (master_select) begin
                sck_out <= ~sck_out;
            end
            if (last_edge) begin
                state_q <= ST_IDLE;
                edge_cnt_q <= 5'h00;
            end else begin
                edge_cnt_q <= edge_cnt_q + 5'h01;
            end
        end else if (!busy) begin
            sck_out <= clock_idle_polarity;
        end
    end
end

// ****************************************
// control register and mode fault
// ****************************************
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        ctrl_q <= `CTRL_RESET;
        ctrl_seen_q <= 1'b0;
    end else begin
        if (acc && sel_ctrl && mode_fault_flag_q) begin
            ctrl_seen_q <= 1'b1;
        end
        if (ctrl_wr) begin
            ctrl_q <= pwdata[7:0];
            // enable and master stay low while the fault is pending
            if (mode_fault_flag_q && !ctrl_seen_q) begin
                ctrl_q[`CTRL_EN] <= 1'b0;
                ctrl_q[`CTRL_MASTER_SELECT] <= 1'b0;
            end
            ctrl_seen_q <= 1'b0;
        end
        if (fault) begin
            ctrl_q[`CTRL_EN] <= 1'b0;
            ctrl_q[`CTRL_MASTER_SELECT] <= 1'b0;
        end
    end
end

// ****************************************
// status flags; a setting event wins over a clear in the same cycle
// ****************************************
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        csr_sw_q <= `CSR_RESET;
        csr_seen_q <= 1'b0;
        write_collision_flag_seen_q <= 1'b0;
    end else begin
        if (wr && sel_csr) begin
            csr_sw_q <= pwdata[7:0] & `CSR_SW_MASK;
        end
        if (csr_acc) begin
            csr_seen_q <= done_q;
            write_collision_flag_seen_q <= write_collision_flag_q;
        end else if (data_acc) begin
            csr_seen_q <= 1'b0;
            write_collision_flag_seen_q <= 1'b0;
        end
    end
end

// ****************************************
// transfer done flag and receive buffer
// ****************************************
// the buffer keeps the first unread byte when an overrun follows
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        done_q <= 1'b0;
        rx_buf_q <= 8'h00;
    end else if (byte_end) begin
        done_q <= 1'b1;
        if (!done_q || done_clr) begin
            rx_buf_q <= rx_byte;
        end
    end else if (done_clr) begin
        done_q <= 1'b0;
    end
end

// ****************************************
// overrun flag
// ****************************************
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        ovr_q <= 1'b0;
    end else if (byte_end && done_q && !done_clr) begin
        ovr_q <= 1'b1;
    end else if (csr_rd) begin
        ovr_q <= 1'b0;
    end
end

// ****************************************
// write collision flag
// ****************************************
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        write_collision_flag_q <= 1'b0;
    end else if (data_wr && busy) begin
        write_collision_flag_q <= 1'b1;
    end else if (data_acc && write_collision_flag_seen_q) begin
        write_collision_flag_q <= 1'b0;
    end
end

// ****************************************
// mode fault flag
// ****************************************
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        mode_fault_flag_q <= 1'b0;
    end else if (fault) begin
        mode_fault_flag_q <= 1'b1;
    end else if (ctrl_wr && ctrl_seen_q) begin
        mode_fault_flag_q <= 1'b0;
    end
end

// ****************************************
// read data, pins and interrupt
// ****************************************
always @* begin
    prdata = 32'h0000_0000;
    if (sel_data) begin
        prdata[7:0] = rx_buf_q;
    end else if (sel_ctrl) begin
        prdata[7:0] = ctrl_q;
    end else if (sel_csr) begin
        prdata[7:0] = {done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, 1'b0, csr_sw_q[2:0]};
    end
end

wire drive_ok = en && !csr_sw_q[`CSR_OD];
assign sck_oe = en && master_select;
assign mosi_out = sdo;
assign mosi_oe = drive_ok && master_select;
assign miso_out = sdo;
// a slave drives only while selected so several slaves can share the line
assign miso_oe = drive_ok && !master_select && !ss_level;
assign irq = ctrl_q[`CTRL_IE] && (done_q || mode_fault_flag_q || ovr_q);
endmodule // spi_port

// ===== rtl/spi_port_regs.vh
// register offsets, field positions, reset values and transfer length of the serial port
`ifndef SPI_PORT_REGS_VH
`define SPI_PORT_REGS_VH
// ****************************************
// register byte addresses (offsets are all multiples of four: index times four)
// ****************************************
`define DATA_IDX 8'h21
`define CTRL_IDX 8'h22
`define CSR_IDX 8'h23
`define DATA_ADDR 10'h084
`define CTRL_ADDR 10'h088
`define CSR_ADDR 10'h08C
// ****************************************
// control register fields
// ****************************************
`define CTRL_IE 7
`define CTRL_EN 6
`define CTRL_DIVH 5
`define CTRL_MASTER_SELECT 4
`define CTRL_CLOCK_IDLE_POLARITY 3
`define CTRL_CLOCK_CAPTURE_PHASE 2
`define CTRL_RESET 8'h00
// ****************************************
// control/status register fields
// ****************************************
`define CSR_DONE 7
`define CSR_WRITE_COLLISION_FLAG 6
`define CSR_OVR 5
`define CSR_MODE_FAULT_FLAG 4
`define CSR_OD 2
`define CSR_SSM 1
`define CSR_SSI 0
`define CSR_RESET 8'h00
`define CSR_SW_MASK 8'h07
// ****************************************
// transfer length
// ****************************************
`define BITS_PER_BYTE 4'h8
`endif

// ===== rtl/spi_clk_div.v
// master baud divider: one-cycle enable per half period of the serial clock
module spi_clk_div (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // control
    input wire run,
    input wire [2:0] div_sel,
    // half-period enable
    output reg half_tick
);
// ****************************************
// divider
// ****************************************
reg [5:0] cnt_q;
reg [5:0] half_lim;

// half-period count minus one; {high, low[1:0]}
always @* begin
    case (div_sel)
        3'h4: half_lim = 6'h01;
        3'h0: half_lim = 6'h03;
        3'h1: half_lim = 6'h07;
        3'h6: half_lim = 6'h0F;
        3'h2: half_lim = 6'h1F;
        3'h3: half_lim = 6'h3F;
        default: half_lim = 6'h03; // unlisted codes fall back to divide by 8
    endcase
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        cnt_q <= 6'h00;
        half_tick <= 1'b0;
    end else if (!run) begin
        cnt_q <= 6'h00;
        half_tick <= 1'b0;
    end else if (cnt_q >= half_lim) begin
        cnt_q <= 6'h00;
        half_tick <= 1'b1;
    end else begin
        cnt_q <= cnt_q + 6'h01;
        half_tick <= 1'b0;
    end
end
endmodule // spi_clk_div

// ===== rtl/spi_shifter.v
// eight-bit shift register, msb first, shared by transmit and receive
module spi_shifter (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // control
    input wire load,
    input wire [7:0] load_data,
    input wire sample,
    input wire shift,
    input wire din,
    // data
    output wire dout,
    output reg [7:0] data_q
);
// ****************************************
// shifter
// ****************************************
reg in_bit_q;

assign dout = data_q[7];

// the sampled bit is held until the shift edge so capture and launch may fall on different edges
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        data_q <= 8'h00;
        in_bit_q <= 1'b0;
    end else if (load) begin
        data_q <= load_data;
    end else begin
        if (sample) begin
            in_bit_q <= din;
        end
        if (shift) begin
            data_q <= {data_q[6:0], in_bit_q};
        end
    end
end
endmodule // spi_shifter

// ===== testbench/spi_partner.sv
// slave model on the far side of the master link
module spi_partner (
    // link
    input logic sck,
    input logic mosi,
    input logic sel_n,
    output logic miso,
    // bench side
    input logic [7:0] tx,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh_q = 8'h00;
    // idle low, capture on rise, shift on fall: same mode as the port
    always @(negedge sck or posedge sel_n) begin
        if (sel_n) sh_q <= tx;
        else sh_q <= {sh_q[6:0], 1'b0};
    end
    always @(posedge sck) begin
        if (!sel_n) rx <= {rx[6:0], mosi};
    end
    // deselected line shows the inverse, so a stale bit never passes
    assign miso = sel_n ? ~sh_q[7] : sh_q[7];
endmodule // spi_partner

// ===== testbench/spi_port_asserts.sv
// property checker bound to the serial port
`include "spi_port_regs.vh"
module spi_port_asserts (
    // clock and reset
    input logic sys_clk,
    input logic rst_n,
    // apb
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pslverr,
    // pins
    input logic sck_out,
    input logic sck_oe,
    input logic mosi_oe,
    input logic miso_oe,
    input logic ss_n_in,
    input logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic ie_q, ssm_q;
    wire acc = psel && penable;
    wire map = paddr == {2'h0, `DATA_ADDR} || paddr == {2'h0, `CTRL_ADDR} || paddr == {2'h0, `CSR_ADDR};
    wire csr = paddr == {2'h0, `CSR_ADDR};
    // tracked from writes: hardware never alters these two bits
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_q <= 1'b0;
            ssm_q <= 1'b0;
        end else if (acc && pwrite) begin
            if (paddr == {2'h0, `CTRL_ADDR}) ie_q <= pwdata[`CTRL_IE];
            if (csr) ssm_q <= pwdata[`CSR_SSM];
        end
    end
    property p_unmapped;
        acc && !pwrite && !map |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
    property p_mapped;
        acc && map |-> !pslverr && prdata[31:8] == 24'h0;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_irq;
        acc && !pwrite && csr && ie_q && prdata[`CSR_DONE] |-> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("done flag without request");
    property p_irq_off;
        !ie_q |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("request while disabled");
    property p_roles;
        !(mosi_oe && miso_oe);
    endproperty
    a_roles: assert property (p_roles) else $error("both data outputs driven");
    property p_mosi;
        mosi_oe |-> sck_oe;
    endproperty
    a_mosi: assert property (p_mosi) else $error("master output without clock");
    property p_fault;
        sck_oe && !ss_n_in && !ssm_q |-> ##[1:4] !sck_oe;
    endproperty
    a_fault: assert property (p_fault) else $error("fault kept master");
    property p_rate;
        sck_oe && $changed(sck_out) |=> $stable(sck_out);
    endproperty
    a_rate: assert property (p_rate) else $error("clock faster than quarter rate");
endmodule // spi_port_asserts
bind spi_port spi_port_asserts chk (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pslverr, .sck_out, .sck_oe, .mosi_oe, .miso_oe, .ss_n_in, .irq);

// ===== testbench/spi_port_tb.sv
// self-checking bench for the serial port
`include "spi_port_regs.vh"
module spi_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // ****
    // wiring
    // ****
    localparam logic [11:0] DA = {2'h0, `DATA_ADDR};
    localparam logic [11:0] CA = {2'h0, `CTRL_ADDR};
    localparam logic [11:0] SA = {2'h0, `CSR_ADDR};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic ss_n_in = 1'b1;
    // starts low so that the first frame's rising select loads the partner
    logic sel_n = 1'b0;
    logic [7:0] ptx = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq, pmiso, e;
    logic [7:0] prx, r;
    logic [2:0] cd [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
    logic [7:0] hp [6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    int errors = 0;
    int checks = 0;
    int n;
    // undriven clock pulled low, mosi pulled high, miso taken from the partner
    wire sck = sck_oe ? sck_out : 1'b0;
    wire mosi = mosi_oe ? mosi_out : 1'b1;
    wire miso = miso_oe ? miso_out : pmiso;
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    spi_port dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sck_in(sck), .sck_out, .sck_oe, .mosi_in(mosi), .mosi_out, .mosi_oe, .miso_in(miso), .miso_out,
        .miso_oe, .ss_n_in, .irq);
    spi_partner far (.sck, .mosi, .sel_n, .miso(pmiso), .tx(ptx), .rx(prx));
    // ****
    // tasks
    // ****
    task automatic end_of_test;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic hang;
        errors++;
        $display("CHECK FAILED wait expected event seen timeout");
        end_of_test();
    endtask
    task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
        checks++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            if (++n > 20) hang();
        end while (pready !== 1'b1);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input string s, input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk(s, x, r);
    endtask
    task automatic xfer(input logic [7:0] t, input logic [7:0] d);
        ptx <= t;
        sel_n <= 1'b1;
        @(posedge sys_clk);
        sel_n <= 1'b0;
        apb(1'b1, DA, d);
    endtask
    task automatic wirq;
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge sys_clk);
            if (++n > 2000) hang();
        end
    endtask
    task automatic edge_gap;
        logic s;
        s = sck_out;
        n = 0;
        while (sck_out === s) begin
            @(posedge sys_clk);
            if (++n > 400) hang();
        end
    endtask
    // ****
    // sequence
    // ****
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rc("ctrl_reset", CA, 8'h00);
        rc("csr_reset", SA, 8'h00);
        apb(1'b0, 12'h090, 8'h00);
        chk("unmapped", 8'h01, {7'h0, e});
        apb(1'b1, CA, 8'hF0);
        xfer(8'h3C, 8'hA5);
        chk("clock_drive", 8'h01, {7'h0, sck_oe});
        wirq();
        chk("far_rx", 8'hA5, prx);
        rc("done_set", SA, 8'h80);
        rc("rx_buffer", DA, 8'h3C);
        rc("done_clear", SA, 8'h00);
        xfer(8'h96, 8'h11);
        apb(1'b1, DA, 8'h22);
        wirq();
        apb(1'b1, DA, 8'h55);
        chk("direct_load", 8'h11, prx);
        rc("collision", SA, 8'hC0);
        rc("rx_second", DA, 8'h96);
        repeat (40) @(posedge sys_clk);
        chk("ignored_write", 8'h11, prx);
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, CA, {2'b11, cd[k][2], 3'b100, cd[k][1:0]});
            xfer(8'h00, 8'h81);
            edge_gap();
            edge_gap();
            chk("half_period", hp[k], n[7:0]);
            wirq();
            rc("div_done", SA, 8'h80);
            apb(1'b0, DA, 8'h00);
        end
        apb(1'b1, CA, 8'h00);
        apb(1'b1, CA, 8'h58);
        apb(1'b1, SA, 8'h04);
        @(posedge sys_clk);
        chk("idle_high", 8'h01, {7'h0, sck_out});
        chk("out_off", 8'h00, {7'h0, mosi_oe});
        apb(1'b1, SA, 8'h03);
        ss_n_in <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rc("pin_ignored", CA, 8'h58);
        apb(1'b1, CA, 8'h48);
        apb(1'b1, SA, 8'h02);
        @(posedge sys_clk);
        chk("slave_out", 8'h01, {7'h0, miso_oe});
        chk("clock_in", 8'h00, {7'h0, sck_oe});
        apb(1'b1, SA, 8'h00);
        apb(1'b1, CA, 8'h00);
        ss_n_in <= 1'b1;
        apb(1'b1, CA, 8'hF0);
        ss_n_in <= 1'b0;
        wirq();
        rc("fault_ctrl", CA, 8'hA0);
        rc("fault_csr", SA, 8'h10);
        ss_n_in <= 1'b1;
        apb(1'b1, CA, 8'h20);
        rc("fault_clear", SA, 8'h00);
        chk("irq_low", 8'h00, {7'h0, irq});
        end_of_test();
    end
endmodule // spi_port_tb
